// ==== spic_pkg.sv ====
/*
  Constants, timing counts and enumerations shared by the sector program
  and identification host controller and its data FIFO.
  Assumes a 200 MHz system clock; all pin timings are derived from it.
*/
package spic_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SECTOR_BYTES = 64;
  localparam int BYTE_IDX_W = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMER_W = 8;
  localparam int WAIT_W = 16;
  localparam int WC_W = 23;

  // clock period and pin timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS = 200;
  localparam int T_WPH_NS = 200;
  localparam int T_ACC_NS = 150;
  localparam int T_OEHP_NS = 150;
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int T_WC_MS = 20;

  // least times round up, longest times round down
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1)
                          / CLK_PERIOD_PS;
  localparam int WPH_CYC = (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int OEHP_CYC = (T_OEHP_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int BYTE_LOAD_WINDOW_CYC = (BYTE_LOAD_WINDOW_US * 1000000)
                                        / CLK_PERIOD_PS;
  localparam int WRITE_CYCLE_CYC = (T_WC_MS * 1000000) / CLK_PERIOD_PS * 1000;
  // one full write access, subtracted from the byte load window as margin
  localparam int LOAD_SLACK_CYC = SETUP_CYC + WP_CYC + WPH_CYC + 4;

  // command code addresses and data
  localparam logic [ADDR_W-1:0] CODE_ADDR_A = 15'h5555;
  localparam logic [ADDR_W-1:0] CODE_ADDR_B = 15'h2AAA;
  localparam logic [DATA_W-1:0] CODE_DATA_1 = 8'hAA;
  localparam logic [DATA_W-1:0] CODE_DATA_2 = 8'h55;
  localparam logic [DATA_W-1:0] CODE_PROGRAM = 8'hA0;
  localparam logic [DATA_W-1:0] CODE_ID_ENTRY = 8'h90;
  localparam logic [DATA_W-1:0] CODE_ID_EXIT = 8'hF0;
  localparam logic [1:0] CODE_LAST_IDX = 2'h2;
  localparam logic [ADDR_W-1:0] ID_ADDR_MAKER = 15'h0000;
  localparam logic [ADDR_W-1:0] ID_ADDR_PART = 15'h0001;

  typedef enum logic [1:0] {
    CMD_READ,
    CMD_PROGRAM,
    CMD_IDENT
  } spic_cmd_e;

  typedef enum logic [1:0] {
    SEL_PROGRAM,
    SEL_ID_ENTRY,
    SEL_ID_EXIT
  } spic_code_e;

endpackage

// ==== spic_fifo.sv ====
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module spic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PTR_W:0] count_reg, count_next;
  logic push, pop;

  assign in_ready_out = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_in;
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule

// ==== spic_ctrl.sv ====
/*
  Host-side controller for a parallel clockless flash: sector program with
  unlock code, toggle-bit completion polling, identification read, plain
  read. Drives chip select, output enable, write strobe, address and data.
  Assumes data_in is synchronous to clk_sys_in and one command at a time.
*/
`timescale 1ns/1ps
// Contract
// - each byte load carries the sector address on the upper address bits.
// - every sector program loads all 64 bytes; a data-starved load stops early and sets error_out instead.
// - successive byte loads start within the byte load window.
// - each read strobe during programming advances the toggle status.
// - toggle polling keeps one fixed address for every read.
module spic_ctrl
  import spic_pkg::*;
#(
  parameter int BLC_CYC = spic_pkg::BYTE_LOAD_WINDOW_CYC,
  parameter int WC_CYC = spic_pkg::WRITE_CYCLE_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // command port
  input wire logic cmd_valid_in,
  input wire spic_pkg::spic_cmd_e cmd_in,
  input wire logic [spic_pkg::ADDR_W-1:0] cmd_addr_in,
  output logic cmd_ready_out,
  // sector data stream
  input wire logic wr_valid_in,
  input wire logic [spic_pkg::DATA_W-1:0] wr_data_in,
  output logic wr_ready_out,
  // results
  output logic done_out,
  output logic error_out,
  output logic [spic_pkg::DATA_W-1:0] rd_data_out,
  output logic [spic_pkg::DATA_W-1:0] maker_code_out,
  output logic [spic_pkg::DATA_W-1:0] part_code_out,
  // flash pins
  output logic [spic_pkg::ADDR_W-1:0] flash_addr_out,
  output logic [spic_pkg::DATA_W-1:0] flash_data_out,
  output logic flash_data_oe_out,
  input wire logic [spic_pkg::DATA_W-1:0] flash_data_in,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out
);
  import spic_pkg::*;

  localparam logic [WAIT_W-1:0] LOAD_WAIT_MAX =
    WAIT_W'(BLC_CYC - LOAD_SLACK_CYC);
  localparam logic [WC_W-1:0] WC_MAX = WC_W'(WC_CYC);
  localparam logic [WAIT_W-1:0] BLC_WAIT = WAIT_W'(BLC_CYC);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CODE, ST_LOAD, ST_POLL, ST_ID, ST_READ, ST_FINISH
  } spic_state_e;
  typedef enum logic [1:0] {PH_SETUP, PH_STROBE, PH_RECOVER} spic_phase_e;

  spic_state_e state_reg, state_next;
  spic_phase_e phase_reg, phase_next;
  spic_code_e sel_reg, sel_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [1:0] code_idx_reg, code_idx_next;
  logic [BYTE_IDX_W-1:0] byte_idx_reg, byte_idx_next;
  logic [ADDR_W-1:0] base_reg, base_next, addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [DATA_W-1:0] rd_reg, rd_next, maker_reg, maker_next;
  logic [DATA_W-1:0] part_reg, part_next;
  logic busy_reg, busy_next, wr_reg, wr_next;
  logic prev_tog_reg, prev_tog_next, first_reg, first_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic [WC_W-1:0] wc_reg, wc_next;
  logic err_reg, err_next, done_reg, done_next;
  logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic acc_done, issue, issue_wr, pop, strobe;
  logic [ADDR_W-1:0] issue_addr;
  logic [DATA_W-1:0] issue_data, code_data, fifo_data;
  logic fifo_valid;

  spic_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .in_valid_in(wr_valid_in),
    .in_data_in(wr_data_in),
    .in_ready_out(wr_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(pop)
  );

  assign cmd_ready_out = (state_reg == ST_IDLE);
  assign done_out = done_reg;
  assign error_out = err_reg;
  assign rd_data_out = rd_reg;
  assign maker_code_out = maker_reg;
  assign part_code_out = part_reg;
  assign flash_addr_out = addr_reg;
  assign flash_data_out = wdata_reg;
  assign flash_data_oe_out = busy_reg & wr_reg;
  assign flash_ce_n_out = ce_n_reg;
  assign flash_oe_n_out = oe_n_reg;
  assign flash_we_n_out = we_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command code table: two fixed unlock writes, then the command byte

  always_comb begin
    case (sel_reg)
      SEL_PROGRAM: code_data = CODE_PROGRAM;
      SEL_ID_ENTRY: code_data = CODE_ID_ENTRY;
      default: code_data = CODE_ID_EXIT;
    endcase
    if (code_idx_reg == 2'h0) begin
      code_data = CODE_DATA_1;
    end else if (code_idx_reg == 2'h1) begin
      code_data = CODE_DATA_2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access engine and sequencer

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    sel_next = sel_reg;
    timer_next = timer_reg;
    code_idx_next = code_idx_reg;
    byte_idx_next = byte_idx_reg;
    base_next = base_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    rd_next = rd_reg;
    maker_next = maker_reg;
    part_next = part_reg;
    busy_next = busy_reg;
    wr_next = wr_reg;
    prev_tog_next = prev_tog_reg;
    first_next = first_reg;
    wait_next = wait_reg;
    wc_next = wc_reg;
    err_next = err_reg;
    done_next = 1'b0;
    acc_done = 1'b0;
    issue = 1'b0;
    issue_wr = 1'b0;
    issue_addr = base_reg;
    issue_data = '0;
    pop = 1'b0;

    if (busy_reg) begin
      if (timer_reg != '0) begin
        timer_next = timer_reg - 1'b1;
      end else begin
        case (phase_reg)
          PH_SETUP: begin
            phase_next = PH_STROBE;
            timer_next = wr_reg ? TIMER_W'(WP_CYC) : TIMER_W'(ACC_CYC);
          end
          PH_STROBE: begin
            phase_next = PH_RECOVER;
            timer_next = wr_reg ? TIMER_W'(WPH_CYC) : TIMER_W'(OEHP_CYC);
            if (!wr_reg) begin
              rdata_next = flash_data_in;
            end
          end
          default: begin
            busy_next = 1'b0;
            acc_done = 1'b1;
          end
        endcase
      end
    end

    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          base_next = cmd_addr_in;
          code_idx_next = 2'h0;
          byte_idx_next = '0;
          case (cmd_in)
            CMD_PROGRAM: begin
              err_next = 1'b0;
              sel_next = SEL_PROGRAM;
              state_next = ST_CODE;
            end
            CMD_IDENT: begin
              sel_next = SEL_ID_ENTRY;
              state_next = ST_CODE;
            end
            default: state_next = ST_READ;
          endcase
        end
      end
      ST_CODE: begin
        if (acc_done) begin
          if (code_idx_reg == CODE_LAST_IDX) begin
            code_idx_next = 2'h0;
            wait_next = '0;
            case (sel_reg)
              SEL_PROGRAM: state_next = ST_LOAD;
              SEL_ID_ENTRY: state_next = ST_ID;
              default: state_next = ST_FINISH;
            endcase
          end else begin
            code_idx_next = code_idx_reg + 1'b1;
          end
        end else if (!busy_reg) begin
          issue = 1'b1;
          issue_wr = 1'b1;
          issue_addr = (code_idx_reg == 2'h1) ? CODE_ADDR_B : CODE_ADDR_A;
          issue_data = code_data;
        end
      end
      ST_LOAD: begin
        if (acc_done) begin
          wait_next = '0;
          if (byte_idx_reg == BYTE_IDX_W'(SECTOR_BYTES - 1)) begin
            state_next = ST_POLL;
            first_next = 1'b1;
            wc_next = '0;
          end else begin
            byte_idx_next = byte_idx_reg + 1'b1;
          end
        end else if (!busy_reg) begin
          if (fifo_valid) begin
            pop = 1'b1;
            issue = 1'b1;
            issue_wr = 1'b1;
            issue_addr = {base_reg[ADDR_W-1:BYTE_IDX_W], byte_idx_reg};
            issue_data = fifo_data;
          end else if (wait_reg >= LOAD_WAIT_MAX) begin
            // data starved: the device closes the load on its own
            err_next = 1'b1;
            state_next = ST_POLL;
            first_next = 1'b1;
            wc_next = '0;
          end else begin
            wait_next = wait_reg + 1'b1;
          end
        end
      end
      ST_POLL: begin
        wc_next = wc_reg + 1'b1;
        if (acc_done) begin
          prev_tog_next = rdata_reg[TOGGLE_BIT];
          first_next = 1'b0;
          if (!first_reg && (rdata_reg[TOGGLE_BIT] == prev_tog_reg)) begin
            state_next = ST_FINISH;
          end
        end else if (!busy_reg) begin
          if (wc_reg >= WC_MAX) begin
            // timeout only between accesses, so no strobe is left hanging
            err_next = 1'b1;
            state_next = ST_FINISH;
          end else if (first_reg && (wait_reg < BLC_WAIT)) begin
            // programming starts only once the load window has closed
            wait_next = wait_reg + 1'b1;
          end else begin
            issue = 1'b1;
            issue_addr = base_reg;
          end
        end
      end
      ST_ID: begin
        if (acc_done) begin
          if (byte_idx_reg[0]) begin
            part_next = rdata_reg;
            sel_next = SEL_ID_EXIT;
            state_next = ST_CODE;
          end else begin
            maker_next = rdata_reg;
            byte_idx_next = BYTE_IDX_W'(1);
          end
        end else if (!busy_reg) begin
          issue = 1'b1;
          issue_addr = byte_idx_reg[0] ? ID_ADDR_PART : ID_ADDR_MAKER;
        end
      end
      ST_READ: begin
        if (acc_done) begin
          rd_next = rdata_reg;
          state_next = ST_FINISH;
        end else if (!busy_reg) begin
          issue = 1'b1;
        end
      end
      ST_FINISH: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase

    if (issue) begin
      busy_next = 1'b1;
      phase_next = PH_SETUP;
      timer_next = TIMER_W'(SETUP_CYC);
      wr_next = issue_wr;
      addr_next = issue_addr;
      wdata_next = issue_data;
    end

    strobe = busy_next & (phase_next == PH_STROBE);
    ce_n_next = ~strobe;
    we_n_next = ~(strobe & wr_next);
    oe_n_next = ~(strobe & ~wr_next);
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_SETUP;
      sel_reg <= SEL_PROGRAM;
      timer_reg <= '0;
      code_idx_reg <= '0;
      byte_idx_reg <= '0;
      base_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      rd_reg <= '0;
      maker_reg <= '0;
      part_reg <= '0;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      prev_tog_reg <= 1'b0;
      first_reg <= 1'b1;
      wait_reg <= '0;
      wc_reg <= '0;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      sel_reg <= sel_next;
      timer_reg <= timer_next;
      code_idx_reg <= code_idx_next;
      byte_idx_reg <= byte_idx_next;
      base_reg <= base_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      rd_reg <= rd_next;
      maker_reg <= maker_next;
      part_reg <= part_next;
      busy_reg <= busy_next;
      wr_reg <= wr_next;
      prev_tog_reg <= prev_tog_next;
      first_reg <= first_next;
      wait_reg <= wait_next;
      wc_reg <= wc_next;
      err_reg <= err_next;
      done_reg <= done_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
    end
  end

endmodule

// ==== spic_ctrl_props.sv ====
/* Checker of spic_ctrl pin sequences, bound to every spic_ctrl.
   Assumes one command at a time on the command port. */
`timescale 1ns/1ps
module spic_ctrl_props
  import spic_pkg::*;
#(
  parameter int BLC_CYC = 30000,
  parameter int WC_CYC = 4000000
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // command port and results
  input wire logic cmd_valid_in,
  input wire spic_cmd_e cmd_in,
  input wire logic [14:0] cmd_addr_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic error_out,
  // flash pins
  input wire logic [14:0] flash_addr_out,
  input wire logic [7:0] flash_data_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out
);
  logic pr_reg, pr_next, wd_reg, wfall;
  logic [14:0] pa_reg, pa_next;
  logic [6:0] wn_reg, wn_next;
  logic [15:0] gap_reg, gap_next;

  // write strobes and load gaps counted from the program command
  assign wfall = wd_reg & ~flash_we_n_out;
  always_comb begin
    pr_next = pr_reg & ~done_out;
    pa_next = pa_reg;
    wn_next = wn_reg + {6'h00, pr_reg & wfall & (wn_reg != 7'h7F)};
    gap_next = wfall ? 16'h0000 : gap_reg;
    if (!wfall && pr_reg && !error_out && wn_reg > 7'h03 && wn_reg < 7'h43)
      gap_next = gap_reg + 16'h0001;
    if (cmd_valid_in && cmd_ready_out) begin
      pr_next = (cmd_in == CMD_PROGRAM);
      pa_next = cmd_addr_in;
      wn_next = 7'h00;
    end
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pr_reg <= 1'b0;
      wd_reg <= 1'b1;
      pa_reg <= 15'h0000;
      wn_reg <= 7'h00;
      gap_reg <= 16'h0000;
    end else begin
      pr_reg <= pr_next;
      wd_reg <= flash_we_n_out;
      pa_reg <= pa_next;
      wn_reg <= wn_next;
      gap_reg <= gap_next;
    end
  end
////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_oe_high_write: assert property (
    !flash_ce_n_out && !flash_we_n_out |-> flash_oe_n_out)
    else $error("read strobe low during write");
  a_oe_high_pulse: assert property (
    $rose(flash_oe_n_out) |=> flash_oe_n_out [*8])
    else $error("read strobe high time too short");
  a_code_first: assert property (
    wfall && pr_reg && wn_reg == 7'h00 |->
    flash_addr_out == CODE_ADDR_A && flash_data_out == CODE_DATA_1)
    else $error("first unlock write wrong");
  a_code_program: assert property (
    wfall && pr_reg && wn_reg == 7'h02 |->
    flash_addr_out == CODE_ADDR_A && flash_data_out == CODE_PROGRAM)
    else $error("program code write wrong");
  a_load_sector: assert property (
    wfall && pr_reg && wn_reg > 7'h02 && wn_reg < 7'h43 |->
    flash_addr_out == {pa_reg[14:6], 6'(wn_reg - 7'h03)})
    else $error("byte load address wrong");
  a_full_sector: assert property (
    done_out && pr_reg && !error_out |-> wn_reg == 7'h43)
    else $error("program without a full sector");
  a_load_window: assert property (gap_reg <= BLC_CYC)
    else $error("byte loads too far apart");
  a_poll_addr: assert property (
    $fell(flash_oe_n_out) && pr_reg && wn_reg == 7'h43 |->
    flash_addr_out == pa_reg)
    else $error("poll address moved");
  c_prog_ok: cover property (done_out && pr_reg && !error_out);
  c_prog_err: cover property (done_out && error_out);
  c_ident: cover property (cmd_valid_in && cmd_ready_out &&
    cmd_in == CMD_IDENT);
endmodule

bind spic_ctrl spic_ctrl_props #(.BLC_CYC(BLC_CYC), .WC_CYC(WC_CYC))
  spic_ctrl_props_i (.clk_sys_in, .nrst_in, .cmd_valid_in, .cmd_in,
  .cmd_addr_in, .cmd_ready_out, .done_out, .error_out, .flash_addr_out,
  .flash_data_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out);

// ==== spic_flash_model.sv ====
/* Behavioural model of the parallel flash at its pins.
   Assumes a host keeping pin timing; busy_ns_in sets program time. */
`timescale 1ns/1ps
module spic_flash_model
  import spic_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
  parameter int LOAD_NS = 1000
) (
  // flash pins
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  // behaviour control
  input wire logic [31:0] busy_ns_in
);
  logic [7:0] mem [32768];
  logic [7:0] latch [64];
  logic [63:0] loaded = 64'h0;
  logic [8:0] sect = 9'h000;
  logic [1:0] step = 2'h0;
  logic loading = 1'b0;
  logic busy = 1'b0;
  logic id_mode = 1'b0;
  logic tgl = 1'b0;
  realtime last_load, busy_end;
  wire wr_n = ce_n_in | we_n_in;
  wire rd_n = ce_n_in | oe_n_in;

  initial begin
    dq_out = 8'h00;
    dq_oe_out = 1'b0;
    for (int i = 0; i < 32768; i++)
      mem[i] = i[7:0] ^ i[14:7];
  end
  // writes: unlock code, then byte loads into the sector latches
  always @(negedge wr_n) begin
    if (loading) begin
      if (loaded == 64'h0)
        sect = addr_in[14:6];
      if (addr_in[14:6] == sect) begin
        latch[addr_in[5:0]] = dq_in;
        loaded[addr_in[5:0]] = 1'b1;
      end
      last_load = $realtime;
    end else if (!busy) begin
      if (step == 2'h0)
        step = (addr_in == CODE_ADDR_A && dq_in == CODE_DATA_1) ? 2'h1 : 2'h0;
      else if (step == 2'h1)
        step = (addr_in == CODE_ADDR_B && dq_in == CODE_DATA_2) ? 2'h2 : 2'h0;
      else begin
        step = 2'h0;
        loading = (addr_in == CODE_ADDR_A && dq_in == CODE_PROGRAM);
        loaded = 64'h0;
        last_load = $realtime;
        if (addr_in == CODE_ADDR_A && dq_in == CODE_ID_ENTRY)
          id_mode = 1'b1;
        if (addr_in == CODE_ADDR_A && dq_in == CODE_ID_EXIT)
          id_mode = 1'b0;
      end
    end
  end
  always #10 begin
    if (loading && $realtime - last_load > LOAD_NS) begin
      loading = 1'b0;
      busy = 1'b1;
      busy_end = $realtime + busy_ns_in;
    end
    if (busy && $realtime >= busy_end) begin
      for (int i = 0; i < 64; i++)
        mem[{sect, 6'(i)}] = loaded[i] ? latch[i] : ~mem[{sect, 6'(i)}];
      busy = 1'b0;
      step = 2'h0;
    end
  end
  // toggle bit keeps its value across programs, so its start is not fixed
  always @(negedge rd_n) begin
    if (busy)
      tgl = ~tgl;
    if (busy)
      dq_out = {1'b0, tgl, 6'h15};
    else if (id_mode && addr_in[14:1] == 14'h0000)
      dq_out = addr_in[0] ? PART_ID : MAKER_ID;
    else
      dq_out = mem[addr_in];
    dq_oe_out = 1'b1;
  end
  // released lines show the inverse of the last value
  always @(posedge rd_n) begin
    dq_oe_out = 1'b0;
    dq_out = ~dq_out;
  end
endmodule

// ==== testbench.sv ====
/* Self-checking bench: spic_ctrl driving the flash model.
   Assumes package, FIFO, controller, checker and model are compiled. */
`timescale 1ns/1ps
module testbench;
  import spic_pkg::*;
  localparam int BLC = 200;
  localparam int WC = 5000;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'h5A; // arbitrary value
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  spic_cmd_e cmd_in = CMD_READ;
  logic [14:0] cmd_addr_in = 15'h0000;
  logic wr_valid_in = 1'b0;
  logic [7:0] wr_data_in = 8'h00;
  logic [31:0] busy_ns = 32'h0;
  logic cmd_ready_out, wr_ready_out, done_out, error_out, mdl_oe;
  logic [7:0] rd_data_out, maker_code_out, part_code_out, mdl_q;
  logic [14:0] flash_addr_out;
  logic [7:0] flash_data_out, flash_data_in;
  logic flash_data_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
  logic [7:0] exp_mem [32768];
  logic [7:0] q [$];
  int n_acc = 0;
  int n_fail = 0;
  int tests_run = 0;

  spic_ctrl #(.BLC_CYC(BLC), .WC_CYC(WC)) spic_ctrl_i (.clk_sys_in,
    .nrst_in, .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_ready_out,
    .wr_valid_in, .wr_data_in, .wr_ready_out, .done_out, .error_out,
    .rd_data_out, .maker_code_out, .part_code_out, .flash_addr_out,
    .flash_data_out, .flash_data_oe_out, .flash_data_in, .flash_ce_n_out,
    .flash_oe_n_out, .flash_we_n_out);
  spic_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .LOAD_NS(BLC * 5))
    spic_flash_model_i (.ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .addr_in(flash_addr_out),
    .dq_in(flash_data_out), .dq_out(mdl_q), .dq_oe_out(mdl_oe),
    .busy_ns_in(busy_ns));
  assign flash_data_in = (flash_data_oe_out && !mdl_oe) ? flash_data_out
                         : mdl_q;
  always #2.5 clk_sys_in = ~clk_sys_in;

  // byte stream with random stalls; valid held until taken
  always @(posedge clk_sys_in) begin
    if (wr_valid_in && wr_ready_out) begin
      void'(q.pop_front());
      n_acc++;
    end
    if (!wr_valid_in || wr_ready_out) begin
      wr_valid_in <= q.size() > 0 && $urandom_range(3) != 0;
      wr_data_in <= q.size() > 0 ? q[0] : 8'h00;
    end
  end
////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic do_cmd(input spic_cmd_e c, input logic [14:0] a);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (cmd_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= c;
    cmd_addr_in <= a;
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
    @(negedge clk_sys_in);
    while (done_out !== 1'b1 && n < 20000) begin
      n++;
      @(negedge clk_sys_in);
    end
    chk1(done_out, 1'b1);
  endtask
  task automatic load(input logic [8:0] s, input int nb);
    logic [7:0] b;
    for (int i = 0; i < nb; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      if (nb == 64)
        exp_mem[{s, 6'(i)}] = b;
    end
  endtask
  task automatic prog(input logic [8:0] s, input int bns, input logic err);
    busy_ns <= 32'(bns);
    do_cmd(CMD_PROGRAM, {s, 6'($urandom)});
    chk1(error_out, err);
  endtask
  task automatic rb(input logic [8:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      do_cmd(CMD_READ, {s, 6'(i)});
      chk8(rd_data_out, exp_mem[{s, 6'(i)}]);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys_in);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end
  initial begin
    logic [8:0] s;
    for (int i = 0; i < 32768; i++)
      exp_mem[i] = 8'(i) ^ 8'(i >> 7);
    void'($urandom(43617));
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(negedge clk_sys_in);
    chk1(flash_we_n_out & flash_ce_n_out & cmd_ready_out, 1'b1);
    chk1(error_out | done_out, 1'b0);
    do_cmd(CMD_IDENT, 15'h0000);
    chk8(maker_code_out, MAKER);
    chk8(part_code_out, PART);
    rb(9'($urandom), 4);
    s = 9'($urandom_range(500));
    load(s, 64);
    repeat (40) @(negedge clk_sys_in);
    chk8(8'(n_acc), 8'(FIFO_DEPTH));
    chk1(wr_ready_out, 1'b0);
    prog(s, 2000, 1'b0);
    load(s, 64);
    prog(s, 15000, 1'b0);
    rb(s, 64);
    load(s + 9'h001, 10);
    prog(s + 9'h001, 2000, 1'b1);
    repeat (1000) @(negedge clk_sys_in);
    // program outlasting the controller's wait limit
    load(s + 9'h002, 64);
    prog(s + 9'h002, 40000, 1'b1);
    repeat (4000) @(negedge clk_sys_in);
    load(s + 9'h003, 64);
    prog(s + 9'h003, 1000, 1'b0);
    rb(s + 9'h003, 4);
    rb(s + 9'h002, 2);
    chk1(wr_ready_out, 1'b1);
    end_sim;
  end
endmodule
